// ===== core/dcc_pkg.sv
// Purpose: Shared constants for the dual comparator control block
// Assumes: 8-bit registers on a plain strobe port
// Notes:   Offsets are word indices on the register port
package dcc_pkg;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 4;
  // Register offsets
  localparam logic [3:0]  OFF_CTRL0     = 4'h0;
  localparam logic [3:0]  OFF_MODE0     = 4'h1;
  localparam logic [3:0]  OFF_CTRL1     = 4'h2;
  localparam logic [3:0]  OFF_MODE1     = 4'h3;
  localparam logic [3:0]  OFF_IRQ_STAT  = 4'h4;
  localparam logic [3:0]  OFF_IRQ_MASK  = 4'h5;
  localparam logic [3:0]  OFF_RST_SRC   = 4'h6;
  // Control register fields
  localparam int          CTL_ON_BIT    = 7;
  localparam int          CTL_OUT_BIT   = 6;
  localparam int          CTL_RISE_BIT  = 5;
  localparam int          CTL_FALL_BIT  = 4;
  localparam int          CTL_HYP_LSB   = 2;
  localparam int          CTL_HYN_LSB   = 0;
  // Mode register fields
  localparam int          MD_RIE_BIT    = 5;
  localparam int          MD_FIE_BIT    = 4;
  localparam int          MD_RESP_LSB   = 0;
  localparam logic [7:0]  MD_WR_MASK    = 8'h33;
  // Reset values
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  MODE_RST      = 8'h02;
  localparam logic [1:0]  MASK_RST      = 2'h0;
  // Hysteresis select encodings
  localparam logic [1:0]  HYST_OFF      = 2'h0;
  localparam logic [1:0]  HYST_5MV      = 2'h1;
  localparam logic [1:0]  HYST_10MV     = 2'h2;
  localparam logic [1:0]  HYST_15MV     = 2'h3;
endpackage : dcc_pkg

// ===== core/dcc_chan_if.sv
// Purpose: Bundle between the top and one comparator channel
// Assumes: Single ref_clk domain
// Notes:   Top owns registers, channel owns edge flags
`timescale 1ns/1ps
interface dcc_chan_if;
  logic       on;         // Comparator enabled
  logic       raw_sync;   // Synchronised comparator output
  logic       clr_rise;   // Software clears rise flag
  logic       clr_fall;   // Software clears fall flag
  logic       rise_flag;  // Sticky rise flag
  logic       fall_flag;  // Sticky fall flag
  logic       rise_en;    // Rise interrupt enable
  logic       fall_en;    // Fall interrupt enable
  logic       irq;        // Channel interrupt request
  logic       rise_pulse; // One-cycle rise event
  logic       fall_pulse; // One-cycle fall event
  modport top  (output on, raw_sync, clr_rise, clr_fall, rise_en, fall_en,
                input rise_flag, fall_flag, irq, rise_pulse, fall_pulse);
  modport chan (input on, raw_sync, clr_rise, clr_fall, rise_en, fall_en,
                output rise_flag, fall_flag, irq, rise_pulse, fall_pulse);
endinterface : dcc_chan_if

// ===== core/dcc_chan.sv
// Purpose: Edge detect and sticky flags for one comparator
// Assumes: raw_sync already synchronised to ref_clk
// Notes:   Set wins over a same-cycle software clear
`timescale 1ns/1ps
module dcc_chan (
  input  wire logic  ref_clk,
  input  wire logic  rst,
  input  wire logic  clk_en,
  dcc_chan_if.chan   ch
);
  logic prev_r;
  logic rise_r;
  logic fall_r;
  logic rise_ev;
  logic fall_ev;

  // Edge events, only while enabled
  assign rise_ev = ch.on & ch.raw_sync & ~prev_r;
  assign fall_ev = ch.on & ~ch.raw_sync & prev_r;

  // Previous sample
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_r <= 1'b0;
    end else if (clk_en) begin
      prev_r <= ch.raw_sync;
    end
  end

  // Sticky flags
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else if (clk_en) begin
      if (rise_ev) begin
        rise_r <= 1'b1;
      end else if (ch.clr_rise) begin
        rise_r <= 1'b0;
      end
      if (fall_ev) begin
        fall_r <= 1'b1;
      end else if (ch.clr_fall) begin
        fall_r <= 1'b0;
      end
    end
  end

  assign ch.rise_flag  = rise_r;
  assign ch.fall_flag  = fall_r;
  assign ch.rise_pulse = rise_ev & clk_en;
  assign ch.fall_pulse = fall_ev & clk_en;
  // Interrupt request, suspended while off
  assign ch.irq = ch.on & ((rise_r & ch.rise_en) | (fall_r & ch.fall_en));
endmodule : dcc_chan

// ===== core/dcc_top.sv
// Purpose: Control and status logic for two analog comparators
// Assumes: Raw comparator outputs are asynchronous to ref_clk
// Notes:   Hysteresis and response codes drive the analog core directly
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module dcc_top (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [1:0]  cmp_raw,
  output logic      [1:0]  cmp_on,
  output logic      [1:0]  cmp_pin_out,
  output logic      [1:0]  pos_hyst_sel0,
  output logic      [1:0]  neg_hyst_sel0,
  output logic      [1:0]  response_sel0,
  output logic      [1:0]  pos_hyst_sel1,
  output logic      [1:0]  neg_hyst_sel1,
  output logic      [1:0]  response_sel1,
  output logic             cmp_irq,
  output logic             irq,
  output logic             cmp_reset_req
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_r   [2];
  logic [7:0] mode_r   [2];
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  logic       rst_src_r;
  logic [7:0] rdata_nxt;
  logic [1:0] ev;

  dcc_chan_if ch0 ();
  dcc_chan_if ch1 ();

  // Decode one register write
  function automatic logic wr_hit(input logic we, input logic [3:0] a, input logic [3:0] off);
    return we & (a == off);
  endfunction : wr_hit

  // Two-stage synchroniser on raw outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else if (clk_en) begin
      sync1_r <= cmp_raw;
      sync2_r <= sync1_r;
    end
  end

  // Control registers, only bit 7 and bits 3:0 stored here
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r[0] <= dcc_pkg::CTRL_RST;
      ctrl_r[1] <= dcc_pkg::CTRL_RST;
    end else if (clk_en) begin
      if (wr_hit(reg_wr, reg_addr, dcc_pkg::OFF_CTRL0)) begin
        ctrl_r[0] <= reg_wdata & 8'h8F;
      end
      if (wr_hit(reg_wr, reg_addr, dcc_pkg::OFF_CTRL1)) begin
        ctrl_r[1] <= reg_wdata & 8'h8F;
      end
    end
  end

  // Mode registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_r[0] <= dcc_pkg::MODE_RST;
      mode_r[1] <= dcc_pkg::MODE_RST;
    end else if (clk_en) begin
      if (wr_hit(reg_wr, reg_addr, dcc_pkg::OFF_MODE0)) begin
        mode_r[0] <= reg_wdata & dcc_pkg::MD_WR_MASK;
      end
      if (wr_hit(reg_wr, reg_addr, dcc_pkg::OFF_MODE1)) begin
        mode_r[1] <= reg_wdata & dcc_pkg::MD_WR_MASK;
      end
    end
  end

  // Reset source enable, comparator zero only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rst_src_r <= 1'b0;
    end else if (clk_en && wr_hit(reg_wr, reg_addr, dcc_pkg::OFF_RST_SRC)) begin
      rst_src_r <= reg_wdata[0];
    end
  end

  // Channel hookup
  assign ch0.on       = ctrl_r[0][dcc_pkg::CTL_ON_BIT];
  assign ch0.raw_sync = sync2_r[0];
  assign ch0.rise_en  = mode_r[0][dcc_pkg::MD_RIE_BIT];
  assign ch0.fall_en  = mode_r[0][dcc_pkg::MD_FIE_BIT];
  assign ch0.clr_rise = wr_hit(reg_wr, reg_addr, dcc_pkg::OFF_CTRL0) & ~reg_wdata[dcc_pkg::CTL_RISE_BIT];
  assign ch0.clr_fall = wr_hit(reg_wr, reg_addr, dcc_pkg::OFF_CTRL0) & ~reg_wdata[dcc_pkg::CTL_FALL_BIT];
  assign ch1.on       = ctrl_r[1][dcc_pkg::CTL_ON_BIT];
  assign ch1.raw_sync = sync2_r[1];
  assign ch1.rise_en  = mode_r[1][dcc_pkg::MD_RIE_BIT];
  assign ch1.fall_en  = mode_r[1][dcc_pkg::MD_FIE_BIT];
  assign ch1.clr_rise = wr_hit(reg_wr, reg_addr, dcc_pkg::OFF_CTRL1) & ~reg_wdata[dcc_pkg::CTL_RISE_BIT];
  assign ch1.clr_fall = wr_hit(reg_wr, reg_addr, dcc_pkg::OFF_CTRL1) & ~reg_wdata[dcc_pkg::CTL_FALL_BIT];

  // Channel instances
  dcc_chan u_ch0 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .ch      (ch0)
  );

  dcc_chan u_ch1 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .ch      (ch1)
  );

  // Any edge event per channel
  assign ev = {ch1.rise_pulse | ch1.fall_pulse, ch0.rise_pulse | ch0.fall_pulse};

  // Sticky summary status, write one clears, set wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_r <= 2'h0;
    end else if (clk_en) begin
      if (wr_hit(reg_wr, reg_addr, dcc_pkg::OFF_IRQ_STAT)) begin
        stat_r <= (stat_r & ~reg_wdata[1:0]) | ev;
      end else begin
        stat_r <= stat_r | ev;
      end
    end
  end

  // Summary mask
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_r <= dcc_pkg::MASK_RST;
    end else if (clk_en && wr_hit(reg_wr, reg_addr, dcc_pkg::OFF_IRQ_MASK)) begin
      mask_r <= reg_wdata[1:0];
    end
  end

  // Read mux
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      dcc_pkg::OFF_CTRL0:    rdata_nxt = {ctrl_r[0][7], sync2_r[0] & ch0.on, ch0.rise_flag,
                                          ch0.fall_flag, ctrl_r[0][3:0]};
      dcc_pkg::OFF_MODE0:    rdata_nxt = mode_r[0];
      dcc_pkg::OFF_CTRL1:    rdata_nxt = {ctrl_r[1][7], sync2_r[1] & ch1.on, ch1.rise_flag,
                                          ch1.fall_flag, ctrl_r[1][3:0]};
      dcc_pkg::OFF_MODE1:    rdata_nxt = mode_r[1];
      dcc_pkg::OFF_IRQ_STAT: rdata_nxt = {6'h00, stat_r};
      dcc_pkg::OFF_IRQ_MASK: rdata_nxt = {6'h00, mask_r};
      dcc_pkg::OFF_RST_SRC:  rdata_nxt = {7'h00, rst_src_r};
      default:               rdata_nxt = 8'h00;
    endcase
  end

  // Read data one cycle after strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
    end
  end

  // Analog and pin outputs
  assign cmp_on        = {ch1.on, ch0.on};
  assign cmp_pin_out   = sync2_r & {ch1.on, ch0.on};
  assign pos_hyst_sel0 = ctrl_r[0][dcc_pkg::CTL_HYP_LSB +: 2];
  assign neg_hyst_sel0 = ctrl_r[0][dcc_pkg::CTL_HYN_LSB +: 2];
  assign response_sel0 = mode_r[0][dcc_pkg::MD_RESP_LSB +: 2];
  assign pos_hyst_sel1 = ctrl_r[1][dcc_pkg::CTL_HYP_LSB +: 2];
  assign neg_hyst_sel1 = ctrl_r[1][dcc_pkg::CTL_HYN_LSB +: 2];
  assign response_sel1 = mode_r[1][dcc_pkg::MD_RESP_LSB +: 2];
  assign cmp_irq       = ch0.irq | ch1.irq;
  // Summary interrupt, suspended for a disabled comparator
  assign irq           = |(stat_r & mask_r & {ch1.on, ch0.on});
  // Reset request from comparator zero only, held while its output is low and it is enabled
  assign cmp_reset_req = rst_src_r & ch0.on & ~sync2_r[0];
endmodule : dcc_top

// ===== verification/dcc_chk.sv
// Purpose: Port-level assertions for dcc_top
// Assumes: One ref_clk domain, synchronous active-high rst
// Notes:   Bound to every dcc_top instance
`timescale 1ns/1ps
module dcc_chk (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic [1:0] cmp_raw,
  input wire logic [1:0] cmp_on,
  input wire logic [1:0] cmp_pin_out,
  input wire logic [1:0] pos_hyst_sel0,
  input wire logic [1:0] neg_hyst_sel0,
  input wire logic [1:0] response_sel0,
  input wire logic       cmp_irq,
  input wire logic       irq,
  input wire logic       cmp_reset_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Writes taken at this edge
  logic wc0;
  logic wm0;
  assign wc0 = !rst && clk_en && reg_wr && reg_addr == dcc_pkg::OFF_CTRL0;
  assign wm0 = !rst && clk_en && reg_wr && reg_addr == dcc_pkg::OFF_MODE0;
  ////////////////////////////////////////////////////////////////////////////
  ctrl_on_a: assert property (
    $past(wc0) |-> cmp_on[0] == $past(reg_wdata[7])) else $error("enable bit not applied");
  hyst_sel_a: assert property (
    $past(wc0) |-> {pos_hyst_sel0, neg_hyst_sel0} == $past(reg_wdata[3:0])) else $error("hysteresis not applied");
  resp_sel_a: assert property (
    $past(wm0) |-> response_sel0 == $past(reg_wdata[1:0])) else $error("response not applied");
  pin_off_a: assert property (
    (cmp_pin_out & ~cmp_on) == 2'h0) else $error("pin driven while disabled");
  irq_off_a: assert property (
    cmp_on == 2'h0 |-> !cmp_irq && !irq) else $error("interrupt while disabled");
  rst_src_a: assert property (
    cmp_reset_req |-> cmp_on[0]) else $error("reset request while disabled");
  flag_hold_a: assert property (
    cmp_irq && !reg_wr |=> cmp_irq) else $error("edge flag dropped alone");
  stat_hold_a: assert property (
    irq && !reg_wr |=> irq) else $error("status bit dropped alone");
  pin_sync_a: assert property (
    (clk_en && cmp_on[0] && $stable(cmp_raw[0])) [*5] |-> cmp_pin_out[0] == cmp_raw[0])
    else $error("pin output not following comparator");
  cover property (cmp_irq);
  cover property (irq);
  cover property (cmp_reset_req);
endmodule : dcc_chk
bind dcc_top dcc_chk u_chk (.ref_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .cmp_raw, .cmp_on,
  .cmp_pin_out, .pos_hyst_sel0, .neg_hyst_sel0, .response_sel0, .cmp_irq, .irq, .cmp_reset_req);

// ===== verification/testbench.sv
// Purpose: Self-checking bench for dcc_top against a register model
// Assumes: Inputs driven by non-blocking assignment at rising ref_clk
// Notes:   Random traffic from an xorshift source
`timescale 1ns/1ps
module testbench;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [1:0]  cmp_raw = 2'h0;
  logic [7:0]  reg_rdata;
  logic [1:0]  cmp_on, cmp_pin_out, pos_hyst_sel0, neg_hyst_sel0, response_sel0;
  logic [1:0]  pos_hyst_sel1, neg_hyst_sel1, response_sel1;
  logic        cmp_irq, irq, cmp_reset_req;
  int          errors = 0;
  int          checks_done = 0;
  int unsigned seed = 25094;
  int unsigned r;
  // Model of the register file
  logic [7:0]  m_ctl [2] = '{8'h00, 8'h00};
  logic [7:0]  m_md [2] = '{dcc_pkg::MODE_RST, dcc_pkg::MODE_RST};
  logic [1:0]  m_cur = 2'h0, m_st = 2'h0, m_mk = 2'h0;
  logic        m_rs = 1'b0;
  dcc_top uut (.ref_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmp_raw, .cmp_on,
    .cmp_pin_out, .pos_hyst_sel0, .neg_hyst_sel0, .response_sel0, .pos_hyst_sel1, .neg_hyst_sel1,
    .response_sel1, .cmp_irq, .irq, .cmp_reset_req);
  initial forever #2 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [7:0] m_reg(logic [3:0] a);
    case (a)
      4'h0, 4'h2: return {m_ctl[a[1]][7], m_ctl[a[1]][7] & m_cur[a[1]], m_ctl[a[1]][5:0]};
      4'h1, 4'h3: return m_md[a[1]];
      4'h4: return {6'h00, m_st};
      4'h5: return {6'h00, m_mk};
      4'h6: return {7'h00, m_rs};
      default: return 8'h00;
    endcase
  endfunction : m_reg
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // Register write, ignored in the model when clk_en is low
  task automatic wr(logic [3:0] a, logic [7:0] d, logic en);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    clk_en <= en;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    clk_en <= 1'b1;
    if (en) case (a)
      4'h0, 4'h2: m_ctl[a[1]] = {d[7], 1'b0, d[5:4] & m_ctl[a[1]][5:4], d[3:0]};
      4'h1, 4'h3: m_md[a[1]] = d & dcc_pkg::MD_WR_MASK;
      4'h4: m_st = m_st & ~d[1:0];
      4'h5: m_mk = d[1:0];
      4'h6: m_rs = d[0];
      default: ;
    endcase
  endtask : wr
  task automatic rd(logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk("reg_rdata", reg_rdata, m_reg(a));
  endtask : rd
  // Comparator output change, flags set only while enabled
  task automatic raw(int i, logic v);
    @(posedge ref_clk);
    cmp_raw[i] <= v;
    repeat (6) @(posedge ref_clk);
    if (m_ctl[i][7] && v != m_cur[i]) begin
      m_ctl[i][v ? 5 : 4] = 1'b1;
      m_st[i] = 1'b1;
    end
    m_cur[i] = v;
  endtask : raw
  task automatic outs();
    logic [1:0] on;
    logic [1:0] ie;
    on = {m_ctl[1][7], m_ctl[0][7]};
    for (int i = 0; i < 2; i++) ie[i] = (m_ctl[i][5] & m_md[i][5]) | (m_ctl[i][4] & m_md[i][4]);
    chk("cmp_on", 8'(cmp_on), 8'(on));
    chk("cmp_pin_out", 8'(cmp_pin_out), 8'(on & m_cur));
    chk("hyst0", 8'({pos_hyst_sel0, neg_hyst_sel0}), 8'(m_ctl[0][3:0]));
    chk("hyst1", 8'({pos_hyst_sel1, neg_hyst_sel1}), 8'(m_ctl[1][3:0]));
    chk("resp", 8'({response_sel1, response_sel0}), 8'({m_md[1][1:0], m_md[0][1:0]}));
    chk("cmp_irq", 8'(cmp_irq), 8'(|(on & ie)));
    chk("irq", 8'(irq), 8'(|(m_st & m_mk & on)));
    chk("cmp_reset_req", 8'(cmp_reset_req), 8'(m_rs & on[0] & ~m_cur[0]));
  endtask : outs
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    errors++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(4'(a));
    outs();
    // Enable, settle, clear flags, then arm interrupts and reset source
    wr(dcc_pkg::OFF_CTRL0, 8'h85, 1'b1);
    repeat (8) @(posedge ref_clk);
    wr(dcc_pkg::OFF_CTRL0, 8'hC6, 1'b1);
    wr(dcc_pkg::OFF_MODE0, 8'hFF, 1'b1);
    wr(dcc_pkg::OFF_IRQ_MASK, 8'h03, 1'b1);
    wr(dcc_pkg::OFF_RST_SRC, 8'h01, 1'b1);
    raw(0, 1'b1);
    outs();
    raw(0, 1'b0);
    outs();
    rd(dcc_pkg::OFF_CTRL0);
    for (int n = 0; n < 400; n++) begin
      r = xs();
      if (r[1:0] == 2'h0)
        raw(int'(r[2]), r[3]);
      else
        wr(r[7:4], r[15:8], r[17:16] != 2'h0);
      rd(r[23:20]);
      outs();
    end
    // Mid-run reset returns every register to its reset value
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    m_ctl = '{8'h00, 8'h00};
    m_md = '{dcc_pkg::MODE_RST, dcc_pkg::MODE_RST};
    m_st = 2'h0;
    m_mk = 2'h0;
    m_rs = 1'b0;
    for (int a = 0; a < 8; a++) rd(4'(a));
    outs();
    summarize();
  end
endmodule : testbench
